// ---- verif/flash_fault_adc_bench.sv ----
// Self-checking bench for the flash fault and converter block
`default_nettype none
module flash_fault_adc_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic enable_pin_i = 1'b1;
    logic uvlo_i = 1'b0;
    logic strobe_i = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [3:0] adc_data_i = 4'h0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic reg_wr_i, reg_rd_i, driver_on_o, dynamic_overvoltage_limit_active_o, il_clamp_o, adc_sample_o, hit;
    logic [2:0] soft_start_level_o;
    logic [1:0] adc_channel_o;
    logic [31:0] tbl [7] = '{32'h00070080, 32'h01070040, 32'h02070020, 32'h03074002, 32'h03070002,
        32'h04024F04, 32'h05070000};
    logic [15:0] rv [5] = '{16'h04A4, 16'h0500, 16'h0700, 16'h0800, 16'h0100};
    int failures = 0;
    int check_count = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    host_model host_model_i (.clk_sys_i(clk_sys_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
    flash_fault_adc flash_fault_adc_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .enable_pin_i(enable_pin_i),
        .uvlo_i(uvlo_i), .strobe_i(strobe_i), .ovp_cmp_i(ev[0]), .short_cmp_i(ev[1]), .overtemp_i(ev[2]),
        .il_limit_i(ev[3]), .batt_limit_i(ev[5]), .ind_fault_i(ev[4]), .pa_burst_mask_one_i(ev[6]),
        .pa_burst_mask_two_i(1'b0), .adc_data_i(adc_data_i), .reg_rdata_o(reg_rdata_o),
        .driver_on_o(driver_on_o), .dynamic_overvoltage_limit_active_o(dynamic_overvoltage_limit_active_o), .il_clamp_o(il_clamp_o),
        .soft_start_level_o(soft_start_level_o), .adc_sample_o(adc_sample_o), .adc_channel_o(adc_channel_o));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host_model_i.read_reg(a, d);
        check(what, exp, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host_model_i.write_reg(a, v);
    endtask
    task automatic pulse(input int i);
        @(negedge clk_sys_i);
        ev[i] = 1'b1;
        @(negedge clk_sys_i);
        ev[i] = 1'b0;
    endtask
    task automatic watch(input int n);
        hit = adc_sample_o === 1'b1;
        repeat (n)
        begin
            @(negedge clk_sys_i);
            if (adc_sample_o === 1'b1)
                hit = 1'b1;
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        wait_n(2);
        reset_i = 1'b0;
        wr(8'h05, 8'hFF);
        wr(8'h08, 8'hFC);
        for (int i = 0; i < 5; i++)
            rd_chk("reset value", rv[i][15:8], rv[i][7:0]);
        $display("reset values finished");
        for (int i = 0; i < 7; i++)
        begin
            wr(tbl[i][23:16], tbl[i][15:8]);
            wr(8'h04, 8'h0A);
            wait_n(2);
            check("driver on", 8'h01, {7'h00, driver_on_o});
            pulse(int'(tbl[i][31:24]));
            wait_n(3);
            check("driver after event", {7'h00, i > 3}, {7'h00, driver_on_o});
            rd_chk("mode reg", 8'h04, i > 3 ? 8'h0A : 8'h02);
            rd_chk("fault bits", 8'h05, tbl[i][7:0]);
            rd_chk("fault cleared", 8'h05, 8'h00);
            wr(8'h04, 8'h02);
        end
        rd_chk("dc limit flag", 8'h06, 8'h01);
        rd_chk("dc limit cleared", 8'h06, 8'h00);
        fork
            host_model_i.read_reg(8'h05, d);
            pulse(2);
        join
        rd_chk("fault kept", 8'h05, 8'h20);
        $display("faults finished");
        wr(8'h07, 8'h80);
        wr(8'h04, 8'h0A);
        @(negedge clk_sys_i);
        ev[0] = 1'b1;
        wait_n(4);
        check("limiting", 8'h01, {7'h00, dynamic_overvoltage_limit_active_o});
        check("driver limiting", 8'h01, {7'h00, driver_on_o});
        ev[0] = 1'b0;
        wait_n(3);
        rd_chk("no overvoltage", 8'h05, 8'h00);
        host_model_i.enter_5v();
        wait_n(2);
        check("5 V running", 8'h01, {7'h00, driver_on_o});
        $display("limiting finished");
        adc_data_i = 4'hA;
        wr(8'h04, 8'h0A);
        wr(8'h08, 8'h02);
        watch(3);
        check("temp start", 8'h01, {7'h00, hit});
        check("temp channel", 8'h02, {6'h00, adc_channel_o});
        wait_n(40000);
        rd_chk("result", 8'h08, 8'h2A);
        check("ramp top", 8'h06, {5'h00, soft_start_level_o});
        wr(8'h04, 8'h02);
        wr(8'h08, 8'h01);
        watch(10);
        check("idle start", 8'h00, {7'h00, hit});
        wr(8'h04, 8'h0A);
        watch(10);
        check("held start", 8'h00, {7'h00, hit});
        wr(8'h04, 8'h02);
        watch(5);
        check("deferred start", 8'h01, {7'h00, hit});
        check("vf channel", 8'h01, {6'h00, adc_channel_o});
        wr(8'h02, 8'h0F);
        wr(8'h04, 8'h0A);
        wr(8'h08, 8'h03);
        watch(10);
        check("pin refused", 8'h00, {7'h00, hit});
        wr(8'h02, 8'hCF);
        wr(8'h08, 8'h03);
        watch(3);
        check("pin start", 8'h01, {7'h00, hit});
        check("pin channel", 8'h03, {6'h00, adc_channel_o});
        $display("converter finished");
        wr(8'h04, 8'h2F);
        wr(8'h08, 8'h01);
        strobe_i = 1'b1;
        watch(5);
        check("flash vf wait", 8'h00, {7'h00, hit});
        check("flash on", 8'h01, {7'h00, driver_on_o});
        pulse(6);
        check("flash kept", 8'h01, {7'h00, driver_on_o});
        strobe_i = 1'b0;
        wait_n(3);
        check("flash off", 8'h00, {7'h00, driver_on_o});
        rd_chk("mode after flash", 8'h04, 8'h27);
        rd_chk("mask flag", 8'h05, 8'h08);
        $display("flash finished");
        wr(8'h07, 8'h80);
        enable_pin_i = 1'b0;
        wait_n(2);
        enable_pin_i = 1'b1;
        wait_n(3);
        rd_chk("config after enable", 8'h07, 8'h00);
        rd_chk("timer after enable", 8'h02, 8'h0F);
        wr(8'h07, 8'h80);
        wr(8'h04, 8'h0A);
        uvlo_i = 1'b1;
        wait_n(2);
        uvlo_i = 1'b0;
        wait_n(3);
        rd_chk("config after uvlo", 8'h07, 8'h00);
        rd_chk("mode after uvlo", 8'h04, 8'hA4);
        $display("resets finished");
        end_sim();
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys_i);
        failures++;
        $display("[ERR] run length expected finish seen timeout");
        end_sim();
    end
endmodule
bind flash_fault_adc flash_fault_adc_monitor flash_fault_adc_monitor_i (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .enable_pin_i(enable_pin_i), .uvlo_i(uvlo_i), .short_cmp_i(short_cmp_i), .overtemp_i(overtemp_i),
    .driver_on_o(driver_on_o), .dynamic_overvoltage_limit_active_o(dynamic_overvoltage_limit_active_o), .il_clamp_o(il_clamp_o),
    .soft_start_level_o(soft_start_level_o), .adc_sample_o(adc_sample_o), .adc_channel_o(adc_channel_o));
`default_nettype wire

// ---- verif/flash_fault_adc_monitor.sv ----
// Port assertions for the flash fault and converter block
`default_nettype none
module flash_fault_adc_monitor (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic enable_pin_i,
    input wire logic uvlo_i,
    input wire logic short_cmp_i,
    input wire logic overtemp_i,
    input wire logic driver_on_o,
    input wire logic dynamic_overvoltage_limit_active_o,
    input wire logic il_clamp_o,
    input wire logic [2:0] soft_start_level_o,
    input wire logic adc_sample_o,
    input wire logic [1:0] adc_channel_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    sequence conv_wr(logic [1:0] s);
        reg_wr_i && reg_addr_i == 8'h08 && reg_wdata_i[1:0] == s;
    endsequence
    sequence temp_start;
        ##1 adc_sample_o && adc_channel_o == 2'h2;
    endsequence
    imm_conv_a: assert property (conv_wr(2'h2) ##0 driver_on_o |-> temp_start)
        else $error("temperature start missing");
    idle_defer_a: assert property (conv_wr(2'h1) ##0 !driver_on_o && !$past(driver_on_o) |=> !adc_sample_o)
        else $error("conversion while idle");
    pulse_one_a: assert property (adc_sample_o |=> !adc_sample_o)
        else $error("start pulse too long");
    short_off_a: assert property (short_cmp_i |-> ##[1:3] !driver_on_o)
        else $error("driver kept on after short");
    temp_off_a: assert property (overtemp_i |-> ##[1:3] !driver_on_o)
        else $error("driver kept on after overtemperature");
    dynamic_overvoltage_limit_run_a: assert property (dynamic_overvoltage_limit_active_o && !short_cmp_i && !overtemp_i |-> driver_on_o)
        else $error("driver stopped while limiting");
    clamp_run_a: assert property ($rose(il_clamp_o) |-> driver_on_o)
        else $error("clamp without running driver");
    ramp_max_a: assert property (soft_start_level_o <= 3'h6)
        else $error("ramp beyond top step");
    en_clear_a: assert property ($rose(enable_pin_i) |-> ##[1:3] !driver_on_o)
        else $error("driver on after enable reset");
    uvlo_clear_a: assert property ($fell(uvlo_i) |-> ##[1:3] !driver_on_o)
        else $error("driver on after supply recovery");
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// Host processor model on the register port
`default_nettype none
module host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        @(negedge clk_sys_i);
        d = rdata_i;
    endtask
    // Output off, mode, then enable
    task automatic enter_5v;
        write_reg(8'h04, 8'h00);
        write_reg(8'h04, 8'h01);
        write_reg(8'h04, 8'h09);
    endtask
endmodule
`default_nettype wire

// ---- verilog/flash_ctrl_defines.vh ----
// Register map, field positions and timing for the flash fault and converter logic
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH

`define ADDR_TIMER 8'h02
`define ADDR_MODE 8'h04
`define ADDR_FAULT 8'h05
`define ADDR_EXTRA 8'h06
`define ADDR_CONFIG 8'h07
`define ADDR_ADC 8'h08

`define RST_TIMER 8'h0F
`define RST_MODE 8'hA4
`define RST_CONFIG 8'h00
`define RST_FAULT 8'h00
`define RST_SEL 2'h0
`define RST_RESULT 4'h0

`define TIMER_DUR 3:0
`define TIMER_PIN2 7:6
`define MODE_DRV 1:0
`define MODE_HWSTR 2
`define MODE_OE 3
`define MODE_LEVEL 5
`define CFG_HARD_IL 6
`define CFG_DYNAMIC_OVERVOLTAGE_LIMIT 7
`define ADC_SEL 1:0
`define CONVERSION_RESULT 5:2

`define F_OVP 7
`define F_SC 6
`define F_OT 5
`define F_TO 4
`define F_TX1 3
`define F_IND 2
`define F_IL 1
`define F_TX2 0
`define CRIT_MASK 8'hF0

`define DRV_STBY 2'h0
`define DRV_5V 2'h1
`define DRV_ASSIST 2'h2
`define DRV_FLASH 2'h3
`define SEL_NONE 2'h0
`define SEL_VF 2'h1
`define SEL_TEMP 2'h2
`define SEL_EXT 2'h3
`define PIN2_IND 2'h1
`define PIN2_MASK 2'h2
`define PIN2_ADC 2'h3

`define CLK_KHZ 40000
`define TICK_US 100
`define TICK_CYCLES ((`CLK_KHZ * `TICK_US) / 1000)
`define FLASH_STEP_MS 100
`define FLASH_STEP_TICKS ((`FLASH_STEP_MS * 1000) / `TICK_US)
`define FLASH_SAMPLE_LEAD 14'h0002
`define FLASH_LAST 14'h0001
`define CONV_US 500
`define CONV_TICKS ((`CONV_US) / `TICK_US)
`define CONV_LAST 4'h1
`define SOFT_START_US 600
`define SS_TICKS ((`SOFT_START_US) / `TICK_US)

`endif

// ---- verilog/flash_fault_adc.v ----
// Fault latching, flash timing and converter sequencing of the flash driver
`default_nettype none
`include "flash_ctrl_defines.vh"
module flash_fault_adc (
    input wire clk_sys_i,
    input wire reset_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire enable_pin_i,
    input wire uvlo_i,
    input wire strobe_i,
    input wire ovp_cmp_i,
    input wire short_cmp_i,
    input wire overtemp_i,
    input wire il_limit_i,
    input wire batt_limit_i,
    input wire ind_fault_i,
    input wire pa_burst_mask_one_i,
    input wire pa_burst_mask_two_i,
    input wire [3:0] adc_data_i,
    output reg [7:0] reg_rdata_o,
    output reg driver_on_o,
    output reg dynamic_overvoltage_limit_active_o,
    output reg il_clamp_o,
    output wire [2:0] soft_start_level_o,
    output reg adc_sample_o,
    output reg [1:0] adc_channel_o
);
    localparam S_IDLE = 4'b0001;
    localparam S_DEFER = 4'b0010;
    localparam S_VFWAIT = 4'b0100;
    localparam S_CONV = 4'b1000;
    localparam integer FLASH_STEP = `FLASH_STEP_TICKS;
    localparam integer CONV_LOAD = `CONV_TICKS;

    reg en_prev_reg;
    reg uvlo_prev_reg;
    reg strobe_prev_reg;
    reg [7:0] timer_reg;
    reg [7:0] mode_reg;
    reg [7:0] mode_next;
    reg [7:0] config_reg;
    reg [7:0] fault_reg;
    reg il_hard_reg;
    reg dc_limit_reg;
    reg [1:0] sel_reg;
    reg [3:0] result_reg;
    reg [13:0] flash_cnt_reg;
    reg flash_run_reg;
    reg active_prev_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [3:0] conv_cnt_reg;
    reg conv_start;
    reg [7:0] rdata_next;
    wire tick;

    // Converter channel allowed for the current pin setup
    function sel_ok;
        input [1:0] sel;
        input [1:0] pin2;
        begin
            sel_ok = (sel != `SEL_NONE) && (sel != `SEL_EXT || pin2 == `PIN2_ADC);
        end
    endfunction

    // Flash length in ticks for a duration code
    function [13:0] flash_len;
        input [3:0] dur;
        begin
            flash_len = ({10'h000, dur} + 14'h0001) * FLASH_STEP[13:0];
        end
    endfunction

    wire regs_clear = reset_i | (enable_pin_i & ~en_prev_reg) | (uvlo_prev_reg & ~uvlo_i);
    wire wr_mode = reg_wr_i && reg_addr_i == `ADDR_MODE;
    wire wr_adc = reg_wr_i && reg_addr_i == `ADDR_ADC;
    wire rd_fault = reg_rd_i && reg_addr_i == `ADDR_FAULT;
    wire [1:0] drv = mode_reg[`MODE_DRV];
    wire [1:0] pin2 = timer_reg[`TIMER_PIN2];
    wire oe = mode_reg[`MODE_OE];
    wire fault_hold = (|(fault_reg & `CRIT_MASK)) | il_hard_reg;
    wire active = oe & ~fault_hold & ~uvlo_i;
    wire level_hw = mode_reg[`MODE_HWSTR] & mode_reg[`MODE_LEVEL];
    wire strobe_rise = strobe_i & ~strobe_prev_reg;
    wire flash_sel = active && drv == `DRV_FLASH;
    wire flash_go = flash_sel & ~flash_run_reg &
        (~mode_reg[`MODE_HWSTR] | (mode_reg[`MODE_LEVEL] ? strobe_i : strobe_rise));
    wire expire = flash_run_reg & tick & (flash_cnt_reg == `FLASH_LAST);
    wire timeout_ev = expire & level_hw & strobe_i;
    wire strobe_drop = flash_run_reg & level_hw & ~strobe_i;
    wire flash_finish = (expire & ~timeout_ev) | strobe_drop;
    wire vf_point = flash_run_reg & tick & (flash_cnt_reg == `FLASH_SAMPLE_LEAD);
    // 5 V mode runs as soon as the host has set drive mode then enable
    wire running = active && drv != `DRV_STBY && (drv != `DRV_FLASH || flash_run_reg);
    wire dynamic_overvoltage_limit_on = config_reg[`CFG_DYNAMIC_OVERVOLTAGE_LIMIT];
    wire ovp_ev = running & ovp_cmp_i & ~dynamic_overvoltage_limit_on;
    wire sc_ev = running & short_cmp_i;
    wire il_ev = running & il_limit_i;
    wire il_hard_ev = il_ev & config_reg[`CFG_HARD_IL];
    wire ind_ev = (pin2 == `PIN2_IND) & ind_fault_i;
    wire tx1_ev = flash_run_reg & pa_burst_mask_one_i;
    wire tx2_ev = flash_run_reg & (pin2 == `PIN2_MASK) & pa_burst_mask_two_i;
    wire crit_ev = ovp_ev | sc_ev | overtemp_i | timeout_ev | il_hard_ev;

    wire [7:0] fault_set;
    assign fault_set[`F_OVP] = ovp_ev;
    assign fault_set[`F_SC] = sc_ev;
    assign fault_set[`F_OT] = overtemp_i;
    assign fault_set[`F_TO] = timeout_ev;
    assign fault_set[`F_TX1] = tx1_ev;
    assign fault_set[`F_IND] = ind_ev;
    assign fault_set[`F_IL] = il_ev;
    assign fault_set[`F_TX2] = tx2_ev;

    tick_divider u_tick (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .tick_o(tick)
    );

    soft_start_ramp u_ramp (
        .clk_sys_i(clk_sys_i),
        .reset_i(regs_clear),
        .run_i(running),
        .tick_i(tick),
        .level_o(soft_start_level_o)
    );

    // Pin edge history, cleared only by the system reset
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            en_prev_reg <= 1'b1;
            uvlo_prev_reg <= 1'b0;
            strobe_prev_reg <= 1'b0;
        end
        else
        begin
            en_prev_reg <= enable_pin_i;
            uvlo_prev_reg <= uvlo_i;
            strobe_prev_reg <= strobe_i;
        end
    end

    // Output mode register with hardware clears of the enable
    always @*
    begin
        mode_next = wr_mode ? reg_wdata_i : mode_reg;
        if (wr_mode && fault_hold)
            mode_next[`MODE_OE] = 1'b0;
        if (crit_ev || flash_finish)
            mode_next[`MODE_OE] = 1'b0;
    end

    // Converter sequencing
    always @*
    begin
        state_next = state_reg;
        conv_start = 1'b0;
        case (state_reg)
            S_IDLE:
                state_next = S_IDLE;
            S_DEFER:
            begin
                if (active_prev_reg && !active)
                begin
                    state_next = S_CONV;
                    conv_start = 1'b1;
                end
            end
            S_VFWAIT:
            begin
                if (vf_point)
                begin
                    state_next = S_CONV;
                    conv_start = 1'b1;
                end
                else if (!flash_run_reg && !flash_sel)
                    state_next = S_IDLE;
            end
            S_CONV:
            begin
                if (tick && conv_cnt_reg == `CONV_LAST)
                    state_next = S_IDLE;
            end
            default:
                state_next = S_IDLE;
        endcase
        // Pending pin request dropped once the pin leaves analog use
        if (conv_start && !sel_ok(sel_reg, pin2))
        begin
            state_next = S_IDLE;
            conv_start = 1'b0;
        end
        if (wr_adc && sel_ok(reg_wdata_i[`ADC_SEL], pin2))
        begin
            conv_start = 1'b0;
            if (!active)
                state_next = S_DEFER;
            else if (drv == `DRV_FLASH && reg_wdata_i[`ADC_SEL] == `SEL_VF)
                state_next = S_VFWAIT;
            else
            begin
                state_next = S_CONV;
                conv_start = 1'b1;
            end
        end
        // Empty or refused request cancels any pending one
        else if (wr_adc)
        begin
            state_next = S_IDLE;
            conv_start = 1'b0;
        end
    end

    // Read data selection
    always @*
    begin
        case (reg_addr_i)
            `ADDR_TIMER: rdata_next = timer_reg;
            `ADDR_MODE: rdata_next = mode_reg;
            `ADDR_FAULT: rdata_next = fault_reg;
            `ADDR_EXTRA: rdata_next = {7'h00, dc_limit_reg};
            `ADDR_CONFIG: rdata_next = config_reg;
            `ADDR_ADC: rdata_next = {2'h0, result_reg, sel_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk_sys_i)
    begin
        if (regs_clear)
        begin
            timer_reg <= `RST_TIMER;
            mode_reg <= `RST_MODE;
            config_reg <= `RST_CONFIG;
            fault_reg <= `RST_FAULT;
            il_hard_reg <= 1'b0;
            dc_limit_reg <= 1'b0;
            sel_reg <= `RST_SEL;
            result_reg <= `RST_RESULT;
            flash_cnt_reg <= 14'h0000;
            flash_run_reg <= 1'b0;
            active_prev_reg <= 1'b0;
            state_reg <= S_IDLE;
            conv_cnt_reg <= 4'h0;
            reg_rdata_o <= 8'h00;
            driver_on_o <= 1'b0;
            dynamic_overvoltage_limit_active_o <= 1'b0;
            il_clamp_o <= 1'b0;
            adc_sample_o <= 1'b0;
            adc_channel_o <= `SEL_NONE;
        end
        else
        begin
            if (reg_wr_i && reg_addr_i == `ADDR_TIMER)
                timer_reg <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == `ADDR_CONFIG)
                config_reg <= reg_wdata_i;
            if (wr_adc)
                sel_reg <= reg_wdata_i[`ADC_SEL];
            mode_reg <= mode_next;
            fault_reg <= (rd_fault ? `RST_FAULT : fault_reg) | fault_set;
            il_hard_reg <= (il_hard_reg & ~rd_fault) | il_hard_ev;
            dc_limit_reg <= (dc_limit_reg & ~(reg_rd_i && reg_addr_i == `ADDR_EXTRA)) |
                (running & batt_limit_i);
            if (reg_rd_i)
                reg_rdata_o <= rdata_next;
            if (flash_go)
            begin
                flash_run_reg <= 1'b1;
                flash_cnt_reg <= flash_len(timer_reg[`TIMER_DUR]);
            end
            else if (flash_run_reg && (expire || strobe_drop || !flash_sel))
                flash_run_reg <= 1'b0;
            else if (flash_run_reg && tick)
                flash_cnt_reg <= flash_cnt_reg - 14'h0001;
            active_prev_reg <= active;
            state_reg <= state_next;
            adc_sample_o <= conv_start;
            if (conv_start)
            begin
                adc_channel_o <= wr_adc ? reg_wdata_i[`ADC_SEL] : sel_reg;
                conv_cnt_reg <= CONV_LOAD[3:0];
            end
            else if (state_reg == S_CONV && tick)
            begin
                conv_cnt_reg <= conv_cnt_reg - 4'h1;
                if (conv_cnt_reg == `CONV_LAST)
                    result_reg <= adc_data_i;
            end
            driver_on_o <= running & ~crit_ev;
            dynamic_overvoltage_limit_active_o <= running & dynamic_overvoltage_limit_on & ovp_cmp_i;
            il_clamp_o <= il_ev & ~config_reg[`CFG_HARD_IL];
        end
    end
endmodule
`default_nettype wire

// ---- verilog/soft_start_ramp.v ----
// Digital output current ramp at driver start
`default_nettype none
`include "flash_ctrl_defines.vh"
module soft_start_ramp (
    input wire clk_sys_i,
    input wire reset_i,
    input wire run_i,
    input wire tick_i,
    output reg [2:0] level_o
);
    localparam integer RAMP_TOP = `SS_TICKS;
    always @(posedge clk_sys_i)
    begin
        if (reset_i || !run_i)
            level_o <= 3'h0;
        else if (tick_i && level_o != RAMP_TOP[2:0])
            level_o <= level_o + 3'h1;
    end
endmodule
`default_nettype wire

// ---- verilog/tick_divider.v ----
// Divider giving a one-cycle pulse every tick period
`default_nettype none
`include "flash_ctrl_defines.vh"
module tick_divider (
    input wire clk_sys_i,
    input wire reset_i,
    output reg tick_o
);
    localparam integer TICK_LAST = `TICK_CYCLES - 1;
    reg [11:0] count_reg;

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            count_reg <= 12'h000;
            tick_o <= 1'b0;
        end
        else if (count_reg == TICK_LAST[11:0])
        begin
            count_reg <= 12'h000;
            tick_o <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 12'h001;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire
